// >>> core/ftc_pkg.sv
package ftc_pkg;

   // ****************************************
   // bus and register map (word index, byte address = index * 4)
   // ****************************************
   localparam int ADDR_W = 18;
   localparam int IDX_LSB = 2;
   localparam logic [15:0] IDX_PERIOD = 16'hf400;
   localparam logic [15:0] IDX_EVA = 16'hf404;
   localparam logic [15:0] IDX_EVB = 16'hf406;
   localparam logic [15:0] IDX_CNT = 16'hf408;
   localparam logic [15:0] IDX_CTRL = 16'hf40a;
   localparam logic [15:0] IDX_STAT = 16'hf40b;
   localparam logic [15:0] IDX_MODE = 16'hf40c;
   localparam logic [15:0] IDX_CLK = 16'hf40e;
   localparam logic [15:0] IDX_TRG0 = 16'hf410;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************
   // field layout and reset values
   // ****************************************
   localparam logic [15:0] CLK_MASK = 16'h0773;
   localparam logic [15:0] MODE_MASK = 16'h0183;
   localparam logic [15:0] TRG0_MASK = 16'h0001;
   localparam logic [15:0] PERIOD_RST = 16'hffff;
   localparam int SRC_LSB = 0;
   localparam int DIV_LSB = 4;
   localparam int XCK_LSB = 8;
   localparam int MODE_LSB = 0;
   localparam int OST_BIT = 7;
   localparam int STPO_BIT = 8;
   localparam int ST0_BIT = 0;
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_CLR_BIT = 1;
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_OUT_BIT = 1;
   localparam int STAT_FULLA_BIT = 4;
   localparam int STAT_FULLB_BIT = 5;
   localparam logic [2:0] DIV_RESERVED = 3'h7;
   localparam logic [2:0] DIV_MAX = 3'h6;
   localparam logic [5:0] DIV_ALL = 6'h3f;

   // ****************************************
   // input pin vector layout
   // ****************************************
   localparam int PIN_LOW = 0;
   localparam int PIN_OSC = 1;
   localparam int PIN_HIGH = 2;
   localparam int PIN_EXT = 3;
   localparam int PIN_TRIG = 11;
   localparam int PIN_CAPA = 12;
   localparam int PIN_CAPB = 13;
   localparam int NPIN = 14;

   typedef enum logic [1:0] {
      SRC_LOW = 2'h0,
      SRC_OSC = 2'h1,
      SRC_HIGH = 2'h2,
      SRC_EXT = 2'h3
   } ftc_src_type;

   typedef enum logic [1:0] {
      MODE_TIMER = 2'h0,
      MODE_CAPTURE = 2'h1,
      MODE_PWM1 = 2'h2,
      MODE_PWM2 = 2'h3
   } ftc_mode_type;

   typedef enum logic {
      RUN_STOPPED = 1'b0,
      RUN_ACTIVE = 1'b1
   } ftc_run_type;

   typedef struct packed {
      logic [NPIN-1:0] sync1;
      logic [NPIN-1:0] sync2;
      logic [NPIN-1:0] prev;
      logic [15:0] clk_cfg;
      logic [15:0] trg0;
      logic [15:0] mode;
      logic [15:0] period;
      logic [15:0] eva;
      logic [15:0] evb;
      logic [15:0] cnt;
      logic [5:0] div_cnt;
      ftc_run_type run;
      logic out;
      logic hold_low;
      logic full_a;
      logic full_b;
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic bvalid;
      logic arready;
      logic rvalid;
      logic [15:0] awidx;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      logic [1:0] bresp;
      logic [15:0] rdata;
      logic [1:0] rresp;
   } ftc_state_type;

   localparam ftc_state_type STATE_RST = '{
      period: PERIOD_RST,
      run: RUN_STOPPED,
      default: '0
   };

endpackage : ftc_pkg

// >>> core/ftc_timer_cfg.sv
// Functional notes
// - timer/pwm: one_shot_select 0 reloads, 1 stops after one period.
// - capture auto: each capture overwrites event_reg_a and event_reg_b, read or not.
// - capture auto: the counter restarts from zero at wrap.
// - capture single: a full event register takes no capture until read.
// - capture single: the counter stops at wrap.
// - stop_output_hold 0: output low at stop and until the next period.
// - stop_output_hold 1: level kept at stop, follows the counter on restart.
// - clock_source_sel picks low-speed, oscillator, high-speed or external clock.
// - clock_divide_sel in bits 6 to 4 divides by 1 to 64; code 7 is reserved.
// - ext_clock_input_sel in bits 10 to 8 picks one of eight external pins.
// - trigger_start_disable at bit 0: 0 lets a trigger start the counter, 1 blocks it.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ftc_timer_cfg (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [ftc_pkg::ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [ftc_pkg::ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic low_speed_clock,
   input wire logic oscillator_clock,
   input wire logic high_speed_clock,
   input wire logic [7:0] ext_clock_pin,
   input wire logic trigger_in,
   input wire logic capture_in_a,
   input wire logic capture_in_b,
   output logic timer_out,
   output logic counter_running
);

   // ****************************************
   // state
   // ****************************************
   ftc_pkg::ftc_state_type st_reg;
   ftc_pkg::ftc_state_type st_next;
   logic [ftc_pkg::NPIN-1:0] pins;

   assign pins = {capture_in_b, capture_in_a, trigger_in, ext_clock_pin,
      high_speed_clock, oscillator_clock, low_speed_clock};

   function automatic logic [15:0] merge(
      input logic [15:0] old,
      input logic [15:0] data,
      input logic [1:0] strb,
      input logic [15:0] mask
   );
      logic [15:0] m;
      m = old;
      if (strb[0])
      begin
         m[7:0] = data[7:0];
      end
      if (strb[1])
      begin
         m[15:8] = data[15:8];
      end
      return m & mask;
   endfunction : merge

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      logic [ftc_pkg::NPIN-1:0] edges;
      ftc_pkg::ftc_src_type src;
      ftc_pkg::ftc_mode_type mode;
      logic [2:0] div;
      logic [2:0] xck;
      logic [5:0] div_mask;
      logic tick;
      logic pulse;
      logic ost;
      logic stpo;
      logic do_start;
      logic do_stop;
      logic do_clear;
      logic rd_eva;
      logic rd_evb;
      logic wrap;
      logic [15:0] ridx;
      logic [15:0] cnt_n;
      edges = '0;
      src = ftc_pkg::SRC_LOW;
      mode = ftc_pkg::MODE_TIMER;
      div = '0;
      xck = '0;
      div_mask = '0;
      tick = 1'b0;
      pulse = 1'b0;
      ost = 1'b0;
      stpo = 1'b0;
      do_start = 1'b0;
      do_stop = 1'b0;
      do_clear = 1'b0;
      rd_eva = 1'b0;
      rd_evb = 1'b0;
      wrap = 1'b0;
      ridx = '0;
      cnt_n = '0;
      st_next = st_reg;

      // two-stage synchronisers; only the second stage feeds the edge detect
      st_next.sync1 = pins;
      st_next.sync2 = st_reg.sync1;
      st_next.prev = st_reg.sync2;
      edges = st_reg.sync2 & ~st_reg.prev;

      src = ftc_pkg::ftc_src_type'(st_reg.clk_cfg[ftc_pkg::SRC_LSB +: 2]);
      mode = ftc_pkg::ftc_mode_type'(st_reg.mode[ftc_pkg::MODE_LSB +: 2]);
      div = st_reg.clk_cfg[ftc_pkg::DIV_LSB +: 3];
      xck = st_reg.clk_cfg[ftc_pkg::XCK_LSB +: 3];
      ost = st_reg.mode[ftc_pkg::OST_BIT];
      stpo = st_reg.mode[ftc_pkg::STPO_BIT];

      // ****************************************
      // clock source and prescaler
      // ****************************************
      // sources are selected as tick enables, never as clocks, so no runt pulse
      unique case (src)
         ftc_pkg::SRC_LOW: tick = edges[ftc_pkg::PIN_LOW];
         ftc_pkg::SRC_OSC: tick = edges[ftc_pkg::PIN_OSC];
         ftc_pkg::SRC_HIGH: tick = edges[ftc_pkg::PIN_HIGH];
         ftc_pkg::SRC_EXT: tick = edges[ftc_pkg::PIN_EXT + int'(xck)];
      endcase
      // reserved code falls back to the largest ratio
      if (div == ftc_pkg::DIV_RESERVED)
      begin
         div = ftc_pkg::DIV_MAX;
      end
      div_mask = ~(ftc_pkg::DIV_ALL << div);
      pulse = tick && ((st_reg.div_cnt & div_mask) == div_mask);
      if (tick)
      begin
         st_next.div_cnt = st_reg.div_cnt + 6'h01;
      end

      // ****************************************
      // register bus: write
      // ****************************************
      if (awvalid && st_reg.awready)
      begin
         st_next.aw_got = 1'b1;
         st_next.awidx = awaddr[ftc_pkg::ADDR_W-1:ftc_pkg::IDX_LSB];
      end
      if (wvalid && st_reg.wready)
      begin
         st_next.w_got = 1'b1;
         st_next.wdata = wdata[15:0];
         st_next.wstrb = wstrb[1:0];
      end
      if (bvalid && bready)
      begin
         st_next.bvalid = 1'b0;
      end
      if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid)
      begin
         st_next.aw_got = 1'b0;
         st_next.w_got = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = ftc_pkg::RESP_OKAY;
         case (st_reg.awidx)
            ftc_pkg::IDX_CLK:
            begin
               st_next.clk_cfg = merge(st_reg.clk_cfg, st_reg.wdata, st_reg.wstrb,
                  ftc_pkg::CLK_MASK);
               // restart the prescaler so a new ratio starts from a clean phase
               st_next.div_cnt = '0;
            end
            ftc_pkg::IDX_TRG0:
               st_next.trg0 = merge(st_reg.trg0, st_reg.wdata, st_reg.wstrb,
                  ftc_pkg::TRG0_MASK);
            ftc_pkg::IDX_MODE:
               st_next.mode = merge(st_reg.mode, st_reg.wdata, st_reg.wstrb,
                  ftc_pkg::MODE_MASK);
            ftc_pkg::IDX_PERIOD:
               st_next.period = merge(st_reg.period, st_reg.wdata, st_reg.wstrb, '1);
            ftc_pkg::IDX_EVA:
               st_next.eva = merge(st_reg.eva, st_reg.wdata, st_reg.wstrb, '1);
            ftc_pkg::IDX_EVB:
               st_next.evb = merge(st_reg.evb, st_reg.wdata, st_reg.wstrb, '1);
            ftc_pkg::IDX_CTRL:
            begin
               if (st_reg.wstrb[0])
               begin
                  do_start = st_reg.wdata[ftc_pkg::CTRL_RUN_BIT];
                  do_stop = !st_reg.wdata[ftc_pkg::CTRL_RUN_BIT];
                  do_clear = st_reg.wdata[ftc_pkg::CTRL_CLR_BIT];
               end
            end
            ftc_pkg::IDX_CNT, ftc_pkg::IDX_STAT: ;
            default: st_next.bresp = ftc_pkg::RESP_SLVERR;
         endcase
      end
      st_next.awready = !st_next.aw_got && !st_next.bvalid;
      st_next.wready = !st_next.w_got && !st_next.bvalid;

      // ****************************************
      // register bus: read
      // ****************************************
      if (rvalid && rready)
      begin
         st_next.rvalid = 1'b0;
      end
      if (arvalid && st_reg.arready)
      begin
         ridx = araddr[ftc_pkg::ADDR_W-1:ftc_pkg::IDX_LSB];
         st_next.rvalid = 1'b1;
         st_next.rresp = ftc_pkg::RESP_OKAY;
         st_next.rdata = '0;
         case (ridx)
            ftc_pkg::IDX_CLK: st_next.rdata = st_reg.clk_cfg;
            ftc_pkg::IDX_TRG0: st_next.rdata = st_reg.trg0;
            ftc_pkg::IDX_MODE: st_next.rdata = st_reg.mode;
            ftc_pkg::IDX_PERIOD: st_next.rdata = st_reg.period;
            ftc_pkg::IDX_EVA:
            begin
               st_next.rdata = st_reg.eva;
               rd_eva = 1'b1;
            end
            ftc_pkg::IDX_EVB:
            begin
               st_next.rdata = st_reg.evb;
               rd_evb = 1'b1;
            end
            ftc_pkg::IDX_CNT: st_next.rdata = st_reg.cnt;
            ftc_pkg::IDX_CTRL: st_next.rdata[ftc_pkg::CTRL_RUN_BIT] = st_reg.run;
            ftc_pkg::IDX_STAT:
            begin
               st_next.rdata[ftc_pkg::STAT_RUN_BIT] = st_reg.run;
               st_next.rdata[ftc_pkg::STAT_OUT_BIT] = st_reg.out;
               st_next.rdata[ftc_pkg::STAT_FULLA_BIT] = st_reg.full_a;
               st_next.rdata[ftc_pkg::STAT_FULLB_BIT] = st_reg.full_b;
            end
            default: st_next.rresp = ftc_pkg::RESP_SLVERR;
         endcase
      end
      st_next.arready = !st_next.rvalid;
      // a read releases the event register; a capture in the same cycle wins below, unless single mode finds the register already full
      if (rd_eva)
      begin
         st_next.full_a = 1'b0;
      end
      if (rd_evb)
      begin
         st_next.full_b = 1'b0;
      end

      // ****************************************
      // trigger start
      // ****************************************
      if (edges[ftc_pkg::PIN_TRIG] && !st_reg.trg0[ftc_pkg::ST0_BIT]
         && st_reg.run == ftc_pkg::RUN_STOPPED)
      begin
         do_start = 1'b1;
      end

      // ****************************************
      // counter
      // ****************************************
      cnt_n = st_reg.cnt;
      if (st_reg.run == ftc_pkg::RUN_ACTIVE && pulse)
      begin
         if (st_reg.cnt == st_reg.period)
         begin
            wrap = 1'b1;
            cnt_n = '0;
            if (ost)
            begin
               do_stop = 1'b1;
            end
         end
         else
         begin
            cnt_n = st_reg.cnt + 16'h0001;
         end
      end
      if (do_clear)
      begin
         cnt_n = '0;
      end
      st_next.cnt = cnt_n;

      // ****************************************
      // capture
      // ****************************************
      if (mode == ftc_pkg::MODE_CAPTURE && st_reg.run == ftc_pkg::RUN_ACTIVE)
      begin
         if (edges[ftc_pkg::PIN_CAPA] && (!ost || !st_reg.full_a))
         begin
            st_next.eva = st_reg.cnt;
            st_next.full_a = 1'b1;
         end
         if (edges[ftc_pkg::PIN_CAPB] && (!ost || !st_reg.full_b))
         begin
            st_next.evb = st_reg.cnt;
            st_next.full_b = 1'b1;
         end
      end

      // ****************************************
      // run state and output
      // ****************************************
      if (wrap || do_clear)
      begin
         st_next.hold_low = 1'b0;
      end
      if (st_reg.run == ftc_pkg::RUN_ACTIVE && !do_stop)
      begin
         if (mode == ftc_pkg::MODE_CAPTURE || st_next.hold_low)
         begin
            st_next.out = 1'b0;
         end
         else
         begin
            unique case (mode)
               ftc_pkg::MODE_TIMER: st_next.out = st_reg.out ^ wrap;
               ftc_pkg::MODE_CAPTURE: st_next.out = 1'b0;
               ftc_pkg::MODE_PWM1: st_next.out = cnt_n < st_reg.eva;
               ftc_pkg::MODE_PWM2: st_next.out = (cnt_n >= st_reg.eva) && (cnt_n < st_reg.evb);
            endcase
         end
      end
      if (do_stop && st_reg.run == ftc_pkg::RUN_ACTIVE)
      begin
         st_next.run = ftc_pkg::RUN_STOPPED;
         // level is frozen by not updating it while stopped
         if (!stpo || mode == ftc_pkg::MODE_CAPTURE)
         begin
            st_next.out = 1'b0;
            st_next.hold_low = 1'b1;
         end
      end
      else if (do_start)
      begin
         st_next.run = ftc_pkg::RUN_ACTIVE;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_reg <= ftc_pkg::STATE_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign awready = st_reg.awready;
   assign wready = st_reg.wready;
   assign bvalid = st_reg.bvalid;
   assign bresp = st_reg.bresp;
   assign arready = st_reg.arready;
   assign rvalid = st_reg.rvalid;
   assign rdata = {16'h0000, st_reg.rdata};
   assign rresp = st_reg.rresp;
   assign timer_out = st_reg.out;
   assign counter_running = st_reg.run;

endmodule : ftc_timer_cfg
`default_nettype wire

// >>> test/ftc_timer_cfg_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ftc_timer_cfg_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [ftc_pkg::ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [31:0] wdata,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic timer_out,
   input wire logic counter_running
);
   // ****************************************
   // shadow of mode and trigger words, full-word writes only
   // ****************************************
   logic [15:0] idx_reg;
   logic [15:0] dat_reg;
   logic [15:0] mode_reg;
   logic [15:0] trg_reg;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_reg <= 16'h0;
         trg_reg <= 16'h0;
      end
      else
      begin
         if (awvalid && awready)
            idx_reg <= awaddr[ftc_pkg::ADDR_W-1:ftc_pkg::IDX_LSB];
         if (wvalid && wready)
            dat_reg <= wdata[15:0];
         // shadow lags the register by a cycle, so it only arms slow relations
         if (bvalid && bready && idx_reg == ftc_pkg::IDX_MODE)
            mode_reg <= dat_reg;
         if (bvalid && bready && idx_reg == ftc_pkg::IDX_TRG0)
            trg_reg <= dat_reg;
      end
   end

   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_wr_both;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_wr_answer;
      !awready && !wready ##1 bvalid;
   endsequence
   property p_wr_answer;
      s_wr_both |=> s_wr_answer;
   endproperty
   a_wr_answer: assert property (p_wr_answer)
      else $error("write answer not on time");
   property p_b_hold;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped early");
   property p_b_block;
      bvalid |-> !awready && !wready;
   endproperty
   a_b_block: assert property (p_b_block)
      else $error("write accepted while response pending");
   property p_rd_answer;
      arvalid && arready |=> rvalid && !arready;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read answer not on time");
   property p_r_hold;
      rvalid && !rready |=> rvalid && $stable(rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped early");
   property p_rdata_hi;
      rvalid |-> rdata[31:16] == 16'h0;
   endproperty
   a_rdata_hi: assert property (p_rdata_hi)
      else $error("upper read data not zero");
   property p_stop_low;
      !mode_reg[ftc_pkg::STPO_BIT] && mode_reg[1:0] != 2'h1 && $fell(counter_running)
         |-> ##[0:1] !timer_out;
   endproperty
   a_stop_low: assert property (p_stop_low)
      else $error("output not low after stop");
   property p_stop_hold;
      mode_reg[ftc_pkg::STPO_BIT] && mode_reg[1:0] != 2'h1 && $fell(counter_running)
         |=> $stable(timer_out);
   endproperty
   a_stop_hold: assert property (p_stop_hold)
      else $error("output level not kept after stop");
   property p_trig_block;
      trg_reg[ftc_pkg::ST0_BIT] && !counter_running && awready && $past(awready)
         |=> !counter_running;
   endproperty
   a_trig_block: assert property (p_trig_block)
      else $error("counter started while trigger start blocked");
endmodule : ftc_timer_cfg_checker

bind ftc_timer_cfg ftc_timer_cfg_checker u_chk (.aclk(aclk), .aresetn(aresetn),
   .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
   .wdata(wdata), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
   .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
   .timer_out(timer_out), .counter_running(counter_running));
`default_nettype wire

// >>> test/ftc_timer_cfg_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ftc_timer_cfg_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [17:0] awaddr = 18'h0;
   logic [17:0] araddr = 18'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic [10:0] ck = 11'h0;
   logic trg = 1'b0;
   logic cap = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, timer_out, counter_running;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [31:0] seed = 32'hc8b9;
   int err_count = 0;
   int num_checks = 0;
   logic [15:0] mdl [int];
   logic [15:0] ids [7] = '{ftc_pkg::IDX_PERIOD, ftc_pkg::IDX_EVA, ftc_pkg::IDX_EVB,
      ftc_pkg::IDX_CNT, ftc_pkg::IDX_MODE, ftc_pkg::IDX_CLK, ftc_pkg::IDX_TRG0};

   always #50 aclk = ~aclk;

   ftc_timer_cfg DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .low_speed_clock(ck[0]), .oscillator_clock(ck[1]), .high_speed_clock(ck[2]),
      .ext_clock_pin(ck[10:3]), .trigger_in(trg), .capture_in_a(cap), .capture_in_b(cap),
      .timer_out(timer_out), .counter_running(counter_running));

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xorshift

   function automatic logic [15:0] msk(input logic [15:0] idx);
      case (idx)
         ftc_pkg::IDX_CLK: return ftc_pkg::CLK_MASK;
         ftc_pkg::IDX_MODE: return ftc_pkg::MODE_MASK;
         ftc_pkg::IDX_TRG0: return ftc_pkg::TRG0_MASK;
         default: return 16'hffff;
      endcase
   endfunction : msk

   task automatic end_of_test();
      if (err_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask : chk

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic [3:0] s,
      input logic [1:0] er = ftc_pkg::RESP_OKAY);
      logic a, w, b;
      logic [1:0] r;
      int n = 0;
      awaddr <= {idx, 2'h0};
      wdata <= {16'h0, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(negedge aclk);
         a = awready;
         w = wready;
         b = bvalid;
         r = bresp;
         @(posedge aclk);
         if (a)
            awvalid <= 1'b0;
         if (w)
            wvalid <= 1'b0;
         n++;
      end
      while (!b && n < 300);
      bready <= 1'b0;
      if (!b)
         err_count++;
      chk(32'(r), 32'(er));
      @(posedge aclk);
   endtask : wr

   task automatic rc(input logic [15:0] idx, input logic [15:0] e,
      input logic [1:0] er = ftc_pkg::RESP_OKAY);
      logic a, v;
      logic [31:0] d;
      logic [1:0] r;
      int n = 0;
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(negedge aclk);
         a = arready;
         v = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (a)
            arvalid <= 1'b0;
         n++;
      end
      while (!v && n < 300);
      rready <= 1'b0;
      if (!v)
         err_count++;
      chk(32'(r), 32'(er));
      if (er == ftc_pkg::RESP_OKAY)
         chk(d, {16'h0, e});
      @(posedge aclk);
   endtask : rc

   // write through the model, then read back
   task automatic wm(input logic [15:0] idx, input logic [15:0] d, input logic [3:0] s);
      logic [15:0] m;
      m = {{8{s[1]}}, {8{s[0]}}} & msk(idx);
      mdl[idx] = (mdl[idx] & ~m) | (d & m);
      wr(idx, d, s);
      rc(idx, mdl[idx]);
   endtask : wm

   task automatic ctl(input logic [15:0] d);
      wr(ftc_pkg::IDX_CTRL, d, 4'hf);
   endtask : ctl

   // pulses on one source pin, random levels held four cycles at a time on all others
   task automatic tick(input int pin, input int n);
      logic [31:0] r;
      repeat (n)
      begin
         r = xorshift();
         ck <= r[10:0] | (11'h1 << pin);
         repeat (4) @(posedge aclk);
         ck <= r[26:16] & ~(11'h1 << pin);
         repeat (4) @(posedge aclk);
      end
      repeat (6) @(posedge aclk);
   endtask : tick

   task automatic pulse_cap();
      cap <= 1'b1;
      repeat (4) @(posedge aclk);
      cap <= 1'b0;
      repeat (6) @(posedge aclk);
   endtask : pulse_cap

   // ****************************************
   // sequence
   // ****************************************
   initial
   begin
      repeat (40000) @(posedge aclk);
      err_count++;
      end_of_test();
   end

   initial
   begin
      logic [31:0] r;
      int src;
      foreach (ids[i])
         mdl[ids[i]] = 16'h0;
      mdl[ftc_pkg::IDX_PERIOD] = ftc_pkg::PERIOD_RST;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (ids[i])
         rc(ids[i], mdl[ids[i]]);
      wr(16'hf401, 16'h1234, 4'hf, ftc_pkg::RESP_SLVERR);
      rc(16'hf401, 16'h0, ftc_pkg::RESP_SLVERR);
      wr(ftc_pkg::IDX_CNT, 16'h1234, 4'hf);
      rc(ftc_pkg::IDX_CNT, 16'h0);
      wm(ftc_pkg::IDX_MODE, 16'hffff, 4'hf);
      wm(ftc_pkg::IDX_MODE, 16'h0, 4'hf);
      wm(ftc_pkg::IDX_TRG0, 16'hffff, 4'hf);
      wm(ftc_pkg::IDX_TRG0, 16'h0, 4'hf);
      repeat (16)
      begin
         r = xorshift();
         wm(ftc_pkg::IDX_CLK, r[15:0], r[19:16]);
      end
      // every source, divider code 0 to 6 and external pin code, counted against noise
      for (int i = 0; i < 14; i++)
      begin
         src = (i < 8) ? 3 : (i - 8) % 3;
         ck <= 11'h0;
         ctl(16'h3);
         wm(ftc_pkg::IDX_CLK, 16'((i % 8) << 8 | (i % 7) << 4 | src), 4'hf);
         tick((i < 8) ? 3 + i : src, 3 << (i % 7));
         ctl(16'h0);
         rc(ftc_pkg::IDX_CNT, 16'h3);
      end
      // wrap behaviour: timer auto, timer one-shot, capture auto, capture single
      ck <= 11'h0;
      wm(ftc_pkg::IDX_CLK, 16'h2, 4'hf);
      wm(ftc_pkg::IDX_PERIOD, 16'h3, 4'hf);
      for (int k = 0; k < 4; k++)
      begin
         wm(ftc_pkg::IDX_MODE, 16'(k % 2) << 7 | 16'(k / 2), 4'hf);
         ctl(16'h3);
         tick(2, 6);
         @(negedge aclk);
         chk(32'(counter_running), 32'(k % 2 == 0));
         @(posedge aclk);
         if (k % 2 == 0)
            rc(ftc_pkg::IDX_CNT, 16'h2);
         ctl(16'h2);
      end
      // output at stop and at restart without clear
      for (int s = 0; s < 2; s++)
      begin
         wm(ftc_pkg::IDX_MODE, 16'(s) << 8, 4'hf);
         ctl(16'h3);
         for (int n = 0; n < 8 && timer_out !== 1'b1; n++)
            tick(2, 1);
         ctl(16'h0);
         @(negedge aclk);
         chk(32'(timer_out), 32'(s));
         @(posedge aclk);
         ctl(16'h1);
         @(negedge aclk);
         chk(32'(timer_out), 32'(s));
         @(posedge aclk);
         ctl(16'h2);
      end
      // captures: overwrite in auto, held until read in single
      wm(ftc_pkg::IDX_PERIOD, 16'hffff, 4'hf);
      for (int s = 0; s < 2; s++)
      begin
         wm(ftc_pkg::IDX_MODE, 16'(s) << 7 | 16'h1, 4'hf);
         ctl(16'h3);
         tick(2, 5);
         pulse_cap();
         tick(2, 4);
         pulse_cap();
         rc(ftc_pkg::IDX_EVA, s ? 16'h5 : 16'h9);
         rc(ftc_pkg::IDX_EVB, s ? 16'h5 : 16'h9);
         tick(2, 2);
         pulse_cap();
         rc(ftc_pkg::IDX_EVA, 16'hb);
         rc(ftc_pkg::IDX_EVB, 16'hb);
         ctl(16'h2);
      end
      // trigger start blocked, then allowed
      wm(ftc_pkg::IDX_MODE, 16'h0, 4'hf);
      for (int s = 0; s < 2; s++)
      begin
         wm(ftc_pkg::IDX_TRG0, 16'(1 - s), 4'hf);
         trg <= 1'b1;
         repeat (6) @(posedge aclk);
         trg <= 1'b0;
         repeat (6) @(negedge aclk);
         chk(32'(counter_running), 32'(s));
         @(posedge aclk);
         ctl(16'h2);
      end
      end_of_test();
   end
endmodule : ftc_timer_cfg_tb
`default_nettype wire
